// file: logic/sor_pkg.sv
package sor_pkg;

    // byte offsets inside the high-page window served by this block
    localparam logic [7:0] SOR_OFF_RESET_STATUS = 8'h00;
    localparam logic [7:0] SOR_OFF_DEBUG_FORCE  = 8'h01;
    localparam logic [7:0] SOR_OFF_OPTIONS_ONE  = 8'h02;
    localparam logic [7:0] SOR_OFF_OPTIONS_TWO  = 8'h03;
    localparam logic [7:0] SOR_OFF_PART_ID_HIGH = 8'h06;
    localparam logic [7:0] SOR_OFF_PART_ID_LOW  = 8'h07;

    // debug force-reset field
    localparam int SOR_FORCE_RESET_BIT = 0;

    // options one field positions
    localparam int SOR_O1_TIMEOUT_HI = 7;
    localparam int SOR_O1_TIMEOUT_LO = 6;
    localparam int SOR_O1_STOP_EN    = 5;
    localparam int SOR_O1_I2C_SEL    = 2;

    // options two field positions
    localparam int SOR_O2_WD_CLK_SEL = 7;
    localparam int SOR_O2_WD_WINDOW  = 6;
    localparam int SOR_O2_CMP_CAPT   = 4;
    localparam int SOR_O2_T2_CH1_SEL = 3;
    localparam int SOR_O2_T2_CH0_SEL = 2;
    localparam int SOR_O2_T1_CH1_SEL = 1;
    localparam int SOR_O2_T1_CH0_SEL = 0;

    // implemented bits, write-once bits and reset values
    localparam logic [7:0] SOR_O1_IMPL_MASK = 8'hE4;
    localparam logic [7:0] SOR_O2_IMPL_MASK = 8'hDF;
    localparam logic [7:0] SOR_O2_ONCE_MASK = 8'hC0;
    localparam logic [7:0] SOR_O1_RESET     = 8'hC0;
    localparam logic [7:0] SOR_O2_RESET     = 8'h00;
    localparam logic [7:0] SOR_READ_ZERO    = 8'h00;

    // identification high byte layout
    localparam int         SOR_IDH_TIE_BIT = 7;
    localparam logic [2:0] SOR_IDH_RSVD    = 3'h0;

    // watchdog service keys
    localparam logic [7:0] SOR_KEY_FIRST  = 8'h55;
    localparam logic [7:0] SOR_KEY_SECOND = 8'hAA;

    // watchdog period exponents: base plus step per timeout select code
    localparam int         SOR_WD_CNT_W    = 20;
    localparam logic [4:0] SOR_WD_STEP_MID = 5'h03;
    localparam logic [4:0] SOR_WD_STEP_TOP = 5'h05;

    typedef enum logic {SOR_SVC_IDLE, SOR_SVC_ARMED} sor_svc_t;

endpackage

// file: logic/sor_wdog_if.sv
interface sor_wdog_if;
    import sor_pkg::*;

    logic [1:0] timeout_sel;
    logic       clk_sel;
    logic       window_en;
    logic       status_wr;
    logic [7:0] status_data;
    logic       expire;

    modport ctl (
        output timeout_sel,
        output clk_sel,
        output window_en,
        output status_wr,
        output status_data,
        input  expire
    );

    modport wdt (
        input  timeout_sel,
        input  clk_sel,
        input  window_en,
        input  status_wr,
        input  status_data,
        output expire
    );
endinterface

// file: logic/sor_watchdog.sv
module sor_watchdog
    import sor_pkg::*;
#(
    parameter logic [4:0] SLOW_EXP_BASE = 5'h05,
    parameter logic [4:0] BUS_EXP_BASE  = 5'h0D
)
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic lpo_tick_i,
    sor_wdog_if.wdt   wd
);

    logic [SOR_WD_CNT_W-1:0] count;
    logic [SOR_WD_CNT_W-1:0] next_count;
    sor_svc_t                svc;
    sor_svc_t                next_svc;
    logic                    expire;
    logic                    next_expire;

    function automatic logic [SOR_WD_CNT_W-1:0] period_of(input logic [1:0] sel,
                                                          input logic       bus);
        logic [4:0] e;
        e = bus ? BUS_EXP_BASE : SLOW_EXP_BASE;
        unique case (sel)
            2'h2:    e = e + SOR_WD_STEP_MID;
            2'h3:    e = e + SOR_WD_STEP_TOP;
            default: e = e;
        endcase
        return SOR_WD_CNT_W'(1) << e;
    endfunction

    logic [SOR_WD_CNT_W-1:0] period;
    logic [SOR_WD_CNT_W-1:0] window_start;
    logic                    enabled;
    logic                    tick;
    logic                    window_open;

    always_comb
    begin
        period       = period_of(wd.timeout_sel, wd.clk_sel);
        window_start = period - (period >> 2);
        enabled      = wd.timeout_sel != 2'h0;
        // watchdog clock choice
        tick         = wd.clk_sel | lpo_tick_i;
        // window only counts with the bus clock
        window_open  = !(wd.window_en && wd.clk_sel) || count >= window_start;
    end

    always_comb
    begin
        next_count  = count;
        next_svc    = svc;
        next_expire = 1'b0;
        if (!enabled)
        begin
            next_count = '0;
            next_svc   = SOR_SVC_IDLE;
        end
        else
        begin
            if (tick)
            begin
                if (count == period - 1'b1)
                begin
                    next_expire = 1'b1;
                    next_count  = '0;
                end
                else
                begin
                    next_count = count + 1'b1;
                end
            end
            if (wd.status_wr)
            begin
                if (!window_open)
                begin
                    next_expire = 1'b1;
                end
                else if (wd.status_data == SOR_KEY_FIRST)
                begin
                    next_svc = SOR_SVC_ARMED;
                end
                else if (wd.status_data == SOR_KEY_SECOND)
                begin
                    if (svc == SOR_SVC_ARMED)
                    begin
                        next_count = '0;
                    end
                    next_svc = SOR_SVC_IDLE;
                end
                else
                begin
                    next_expire = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            count  <= '0;
            svc    <= SOR_SVC_IDLE;
            expire <= 1'b0;
        end
        else
        begin
            count  <= next_count;
            svc    <= next_svc;
            expire <= next_expire;
        end
    end

    assign wd.expire = expire;

endmodule

// file: logic/sor_system_options.sv
//////////////////////////////////////////////////////////////////////////////////////////
module sor_system_options
    import sor_pkg::*;
#(
    // arbitrary neutral part number
    parameter logic [11:0] PART_NUMBER   = 12'h5C3,
    parameter logic [4:0]  SLOW_EXP_BASE = 5'h05,
    parameter logic [4:0]  BUS_EXP_BASE  = 5'h0D
)
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       rd_en_i,
    input  wire logic       bdm_access_i,
    input  wire logic       lpo_tick_i,
    input  wire logic       stop_exec_i,
    input  wire logic       cmp_out_i,
    input  wire logic       timer1_ch0_pin_i,
    output logic     [7:0]  rd_data_o,
    output logic            force_reset_o,
    output logic            illegal_op_reset_o,
    output logic            stop_enter_o,
    output logic            wdog_reset_o,
    output logic            stop_mode_enable_o,
    output logic            i2c_pin_select_o,
    output logic            comparator_to_capture_o,
    output logic            timer1_ch0_capture_o,
    output logic            timer2_ch1_pin_select_o,
    output logic            timer2_ch0_pin_select_o,
    output logic            timer1_ch1_pin_select_o,
    output logic            timer1_ch0_pin_select_o
);

    //////////////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic reg_write(input logic       en,
                                       input logic [7:0] addr,
                                       input logic [7:0] off);
        return en && (addr == off);
    endfunction

    logic wr_status;
    logic wr_debug;
    logic wr_opt_one;
    logic wr_opt_two;

    always_comb
    begin
        // user and debug writes decode alike; only the force bit checks the path
        wr_status  = reg_write(wr_en_i, addr_i, SOR_OFF_RESET_STATUS);
        wr_debug   = reg_write(wr_en_i, addr_i, SOR_OFF_DEBUG_FORCE);
        wr_opt_one = reg_write(wr_en_i, addr_i, SOR_OFF_OPTIONS_ONE);
        wr_opt_two = reg_write(wr_en_i, addr_i, SOR_OFF_OPTIONS_TWO);
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // option registers and their write-once locks

    logic [7:0] system_options_one;
    logic [7:0] next_system_options_one;
    logic [7:0] system_options_two;
    logic [7:0] next_system_options_two;
    logic       one_locked;
    logic       next_one_locked;
    logic       two_locked;
    logic       next_two_locked;

    always_comb
    begin
        next_system_options_one = system_options_one;
        next_one_locked         = one_locked;
        next_system_options_two = system_options_two;
        next_two_locked         = two_locked;
        // the lock also guards against a runaway program rewriting the settings
        if (wr_opt_one && !one_locked)
        begin
            next_system_options_one = wr_data_i & SOR_O1_IMPL_MASK;
            next_one_locked         = 1'b1;
        end
        if (wr_opt_two)
        begin
            // free bits always follow, write-once bits only on the first write
            next_system_options_two = (system_options_two & SOR_O2_ONCE_MASK)
                                    | (wr_data_i & SOR_O2_IMPL_MASK & ~SOR_O2_ONCE_MASK);
            if (!two_locked)
            begin
                next_system_options_two = wr_data_i & SOR_O2_IMPL_MASK;
            end
            next_two_locked = 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            // any reset source reopens the registers
            system_options_one <= SOR_O1_RESET;
            one_locked         <= 1'b0;
            system_options_two <= SOR_O2_RESET;
            two_locked         <= 1'b0;
        end
        else
        begin
            system_options_one <= next_system_options_one;
            one_locked         <= next_one_locked;
            system_options_two <= next_system_options_two;
            two_locked         <= next_two_locked;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // watchdog

    sor_wdog_if wd_link ();

    always_comb
    begin
        wd_link.timeout_sel = system_options_one[SOR_O1_TIMEOUT_HI:SOR_O1_TIMEOUT_LO];
        wd_link.clk_sel     = system_options_two[SOR_O2_WD_CLK_SEL];
        wd_link.window_en   = system_options_two[SOR_O2_WD_WINDOW];
        // key order and window timing are tracked inside the watchdog, not here
        wd_link.status_wr   = wr_status;
        wd_link.status_data = wr_data_i;
    end

    sor_watchdog #(
        .SLOW_EXP_BASE (SLOW_EXP_BASE),
        .BUS_EXP_BASE  (BUS_EXP_BASE)
    ) u_watchdog (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .lpo_tick_i (lpo_tick_i),
        .wd         (wd_link.wdt)
    );

    assign wdog_reset_o = wd_link.expire;

    //////////////////////////////////////////////////////////////////////////////////////
    // reset requests and stop handling

    logic next_force_reset;
    logic next_illegal_op_reset;
    logic next_stop_enter;

    always_comb
    begin
        // only the background debug path may set the force bit
        next_force_reset      = wr_debug && bdm_access_i && wr_data_i[SOR_FORCE_RESET_BIT];
        next_illegal_op_reset = 1'b0;
        next_stop_enter       = 1'b0;
        if (stop_exec_i)
        begin
            if (system_options_one[SOR_O1_STOP_EN])
            begin
                next_stop_enter = 1'b1;
            end
            else
            begin
                next_illegal_op_reset = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            force_reset_o      <= 1'b0;
            illegal_op_reset_o <= 1'b0;
            stop_enter_o       <= 1'b0;
        end
        else
        begin
            force_reset_o      <= next_force_reset;
            illegal_op_reset_o <= next_illegal_op_reset;
            stop_enter_o       <= next_stop_enter;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // pin placement and routing outputs

    logic next_capture;
    logic next_stop_mode_enable;
    logic next_i2c_pin_select;
    logic next_comparator_to_capture;
    logic next_timer2_ch1_pin_select;
    logic next_timer2_ch0_pin_select;
    logic next_timer1_ch1_pin_select;
    logic next_timer1_ch0_pin_select;

    always_comb
    begin
        // copies follow the register's next value so they change on the write's own edge
        next_stop_mode_enable      = next_system_options_one[SOR_O1_STOP_EN];
        next_i2c_pin_select        = next_system_options_one[SOR_O1_I2C_SEL];
        next_comparator_to_capture = next_system_options_two[SOR_O2_CMP_CAPT];
        next_timer2_ch1_pin_select = next_system_options_two[SOR_O2_T2_CH1_SEL];
        next_timer2_ch0_pin_select = next_system_options_two[SOR_O2_T2_CH0_SEL];
        next_timer1_ch1_pin_select = next_system_options_two[SOR_O2_T1_CH1_SEL];
        next_timer1_ch0_pin_select = next_system_options_two[SOR_O2_T1_CH0_SEL];
        // comparator replaces the pin only when routing is on
        next_capture = system_options_two[SOR_O2_CMP_CAPT] ? cmp_out_i
                                                           : timer1_ch0_pin_i;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            stop_mode_enable_o      <= SOR_O1_RESET[SOR_O1_STOP_EN];
            i2c_pin_select_o        <= SOR_O1_RESET[SOR_O1_I2C_SEL];
            comparator_to_capture_o <= SOR_O2_RESET[SOR_O2_CMP_CAPT];
            timer1_ch0_capture_o    <= 1'b0;
            timer2_ch1_pin_select_o <= SOR_O2_RESET[SOR_O2_T2_CH1_SEL];
            timer2_ch0_pin_select_o <= SOR_O2_RESET[SOR_O2_T2_CH0_SEL];
            timer1_ch1_pin_select_o <= SOR_O2_RESET[SOR_O2_T1_CH1_SEL];
            timer1_ch0_pin_select_o <= SOR_O2_RESET[SOR_O2_T1_CH0_SEL];
        end
        else
        begin
            stop_mode_enable_o      <= next_stop_mode_enable;
            i2c_pin_select_o        <= next_i2c_pin_select;
            comparator_to_capture_o <= next_comparator_to_capture;
            timer1_ch0_capture_o    <= next_capture;
            timer2_ch1_pin_select_o <= next_timer2_ch1_pin_select;
            timer2_ch0_pin_select_o <= next_timer2_ch0_pin_select;
            timer1_ch1_pin_select_o <= next_timer1_ch1_pin_select;
            timer1_ch0_pin_select_o <= next_timer1_ch0_pin_select;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] part_id_high;
    logic [7:0] part_id_low;
    logic [7:0] next_rd_data;

    always_comb
    begin
        // tie-off bit, reserved as zero, upper part number nibble
        part_id_high = {1'b1, SOR_IDH_RSVD, PART_NUMBER[11:8]};
        part_id_low  = PART_NUMBER[7:0];
        // reads have no side effects, so a stray read never disturbs a lock
        next_rd_data = rd_data_o;
        if (rd_en_i)
        begin
            unique case (addr_i)
                SOR_OFF_DEBUG_FORCE:  next_rd_data = SOR_READ_ZERO;
                SOR_OFF_OPTIONS_ONE:  next_rd_data = system_options_one;
                SOR_OFF_OPTIONS_TWO:  next_rd_data = system_options_two;
                SOR_OFF_PART_ID_HIGH: next_rd_data = part_id_high;
                SOR_OFF_PART_ID_LOW:  next_rd_data = part_id_low;
                // reset status lives elsewhere; unmapped reads give zero
                default:              next_rd_data = SOR_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            rd_data_o <= SOR_READ_ZERO;
        end
        else
        begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule

// file: sim/sor_system_options_assertions.sv
module sor_system_options_chk
    import sor_pkg::*;
#(
    parameter logic [11:0] PART_NUMBER = 12'h5C3 // arbitrary
)
(
    input wire logic       mclk_i,
    input wire logic       reset_i,
    input wire logic [7:0] addr_i,
    input wire logic       wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       rd_en_i,
    input wire logic       bdm_access_i,
    input wire logic       stop_exec_i,
    input wire logic       cmp_out_i,
    input wire logic       timer1_ch0_pin_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       force_reset_o,
    input wire logic       illegal_op_reset_o,
    input wire logic       stop_enter_o,
    input wire logic       stop_mode_enable_o,
    input wire logic       i2c_pin_select_o,
    input wire logic       comparator_to_capture_o,
    input wire logic       timer1_ch0_capture_o,
    input wire logic       timer2_ch1_pin_select_o,
    input wire logic       timer2_ch0_pin_select_o,
    input wire logic       timer1_ch1_pin_select_o,
    input wire logic       timer1_ch0_pin_select_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    // debug writes use up the single option one chance as well
    logic       seen_one;
    logic       next_seen_one;
    logic [7:0] last_data;
    wire        wr_frc = wr_en_i && addr_i == SOR_OFF_DEBUG_FORCE;
    wire        wr_one = wr_en_i && addr_i == SOR_OFF_OPTIONS_ONE;

    always_comb
    begin
        next_seen_one = !reset_i && (seen_one || wr_one);
    end

    always_ff @(posedge mclk_i)
    begin
        seen_one  <= next_seen_one;
        last_data <= wr_data_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_user_force_drop: assert property (
        wr_frc && !(bdm_access_i && wr_data_i[0]) |=> !force_reset_o)
        else $error("force reset without a debug write of one");
    a_debug_force_pulse: assert property (
        wr_frc && bdm_access_i && wr_data_i[0] |=> force_reset_o ##1 !force_reset_o)
        else $error("debug force reset pulse missing");
    a_force_reads_zero: assert property (
        rd_en_i && addr_i == SOR_OFF_DEBUG_FORCE |=> rd_data_o == SOR_READ_ZERO)
        else $error("force reset register read not zero");
    a_part_id_high: assert property (
        rd_en_i && addr_i == SOR_OFF_PART_ID_HIGH
        |=> rd_data_o == {1'b1, SOR_IDH_RSVD, PART_NUMBER[11:8]})
        else $error("part id high byte wrong");
    a_stop_gate: assert property (
        stop_exec_i |=> illegal_op_reset_o == !$past(stop_mode_enable_o)
            && stop_enter_o == $past(stop_mode_enable_o))
        else $error("stop outcome does not follow stop enable");
    a_opt_one_take: assert property (
        wr_one && !seen_one |=> stop_mode_enable_o == last_data[SOR_O1_STOP_EN]
            && i2c_pin_select_o == last_data[SOR_O1_I2C_SEL])
        else $error("first option one write not taken");
    a_opt_one_lock: assert property (
        wr_one && seen_one |=> $stable(stop_mode_enable_o) && $stable(i2c_pin_select_o))
        else $error("option one changed after first write");
    a_opt_two_pins: assert property (
        wr_en_i && addr_i == SOR_OFF_OPTIONS_TWO |=> {comparator_to_capture_o,
            timer2_ch1_pin_select_o, timer2_ch0_pin_select_o, timer1_ch1_pin_select_o,
            timer1_ch0_pin_select_o} == last_data[4:0])
        else $error("option two pin selects not updated");
    a_capture_route: assert property (
        1'b1 |=> timer1_ch0_capture_o == ($past(comparator_to_capture_o)
            ? $past(cmp_out_i) : $past(timer1_ch0_pin_i)))
        else $error("capture input routed wrongly");
endmodule

bind sor_system_options sor_system_options_chk #(.PART_NUMBER(PART_NUMBER)) u_chk (.*);

// file: sim/sor_host_model.sv
module sor_host_model
    import sor_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] rd_data_i,
    output logic      [7:0] addr_o,
    output logic            wr_en_o,
    output logic      [7:0] wr_data_o,
    output logic            rd_en_o,
    output logic            bdm_access_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr_o       = 8'h00;
        wr_en_o      = 1'b0;
        wr_data_o    = 8'h00;
        rd_en_o      = 1'b0;
        bdm_access_o = 1'b0;
    end

    // released address and data lines show the inverse of the last value, so a late sample never matches
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic dbg);
        @(negedge mclk_i);
        addr_o       = a;
        wr_data_o    = d;
        bdm_access_o = dbg;
        wr_en_o      = 1'b1;
        @(negedge mclk_i);
        wr_en_o      = 1'b0;
        bdm_access_o = 1'b0;
        addr_o       = ~a;
        wr_data_o    = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        addr_o  = a;
        rd_en_o = 1'b1;
        @(negedge mclk_i);
        rd_en_o = 1'b0;
        addr_o  = ~a;
        d       = rd_data_i;
    endtask

    task automatic service;
        write_reg(SOR_OFF_RESET_STATUS, SOR_KEY_FIRST, 1'b0);
        write_reg(SOR_OFF_RESET_STATUS, SOR_KEY_SECOND, 1'b0);
    endtask
endmodule

// file: sim/system_option_and_id_registers_tb_top.sv
module system_option_and_id_registers_tb_top
    import sor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // arbitrary part number, only chosen to differ from the design default
    localparam logic [11:0] TB_PART = 12'h3B7;

    logic       mclk_i           = 1'b0;
    logic       reset_i          = 1'b1;
    logic       lpo_tick_i       = 1'b0;
    logic       stop_exec_i      = 1'b0;
    logic       cmp_out_i        = 1'b1;
    logic       timer1_ch0_pin_i = 1'b0;
    logic [7:0] addr_i;
    logic       wr_en_i;
    logic [7:0] wr_data_i;
    logic       rd_en_i;
    logic       bdm_access_i;
    logic [7:0] rd_data_o;
    wire  [3:0] pulses;
    wire  [1:0] opt_one;
    wire  [4:0] opt_two;
    logic       capture;
    int         errors           = 0;
    int         checks           = 0;

    always #10 mclk_i = ~mclk_i;

    sor_system_options #(
        .PART_NUMBER             (TB_PART),
        .SLOW_EXP_BASE           (5'h01),
        .BUS_EXP_BASE            (5'h02)
    ) i_dut (
        .mclk_i                  (mclk_i),
        .reset_i                 (reset_i),
        .addr_i                  (addr_i),
        .wr_en_i                 (wr_en_i),
        .wr_data_i               (wr_data_i),
        .rd_en_i                 (rd_en_i),
        .bdm_access_i            (bdm_access_i),
        .lpo_tick_i              (lpo_tick_i),
        .stop_exec_i             (stop_exec_i),
        .cmp_out_i               (cmp_out_i),
        .timer1_ch0_pin_i        (timer1_ch0_pin_i),
        .rd_data_o               (rd_data_o),
        .force_reset_o           (pulses[0]),
        .illegal_op_reset_o      (pulses[1]),
        .stop_enter_o            (pulses[2]),
        .wdog_reset_o            (pulses[3]),
        .stop_mode_enable_o      (opt_one[1]),
        .i2c_pin_select_o        (opt_one[0]),
        .comparator_to_capture_o (opt_two[4]),
        .timer1_ch0_capture_o    (capture),
        .timer2_ch1_pin_select_o (opt_two[3]),
        .timer2_ch0_pin_select_o (opt_two[2]),
        .timer1_ch1_pin_select_o (opt_two[1]),
        .timer1_ch0_pin_select_o (opt_two[0])
    );

    sor_host_model host (
        .mclk_i       (mclk_i),
        .rd_data_i    (rd_data_o),
        .addr_o       (addr_i),
        .wr_en_o      (wr_en_i),
        .wr_data_o    (wr_data_i),
        .rd_en_o      (rd_en_i),
        .bdm_access_o (bdm_access_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk(d, exp);
    endtask

    // a missing pulse ends the run at once: later steps would only cascade
    task automatic watch(input int k, input int n, input logic e, input logic stp,
                         input logic tick);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            seen        = seen | (pulses[k] === 1'b1);
            stop_exec_i = (i == 0) && stp;
            if (tick)
                lpo_tick_i = ~lpo_tick_i;
            @(negedge mclk_i);
        end
        lpo_tick_i = 1'b0;
        chk({7'h00, seen}, {7'h00, e});
        if (e && !seen)
            summarize();
    endtask

    task automatic rst(input logic [7:0] o1, input logic [7:0] o2);
        reset_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        reset_i = 1'b0;
        host.write_reg(SOR_OFF_OPTIONS_ONE, o1, 1'b0);
        host.write_reg(SOR_OFF_OPTIONS_TWO, o2, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(negedge mclk_i);
        reset_i = 1'b0;
        rdc(SOR_OFF_OPTIONS_ONE, SOR_O1_RESET);
        rdc(SOR_OFF_OPTIONS_TWO, SOR_O2_RESET);
        host.write_reg(SOR_OFF_PART_ID_HIGH, 8'h70, 1'b0);
        host.write_reg(SOR_OFF_PART_ID_LOW, 8'h00, 1'b0);
        rdc(SOR_OFF_PART_ID_HIGH, {1'b1, SOR_IDH_RSVD, TB_PART[11:8]});
        rdc(SOR_OFF_PART_ID_LOW, TB_PART[7:0]);
        host.write_reg(SOR_OFF_DEBUG_FORCE, 8'h01, 1'b0);
        watch(0, 4, 1'b0, 1'b0, 1'b0);
        rdc(SOR_OFF_DEBUG_FORCE, SOR_READ_ZERO);
        rdc(8'h05, SOR_READ_ZERO);
        watch(1, 3, 1'b1, 1'b1, 1'b0);
        host.write_reg(SOR_OFF_OPTIONS_ONE, 8'h24, 1'b0);
        chk({6'h00, opt_one}, 8'h03);
        host.write_reg(SOR_OFF_OPTIONS_ONE, 8'hC0, 1'b1);
        rdc(SOR_OFF_OPTIONS_ONE, 8'h24);
        watch(2, 3, 1'b1, 1'b1, 1'b0);
        host.write_reg(SOR_OFF_OPTIONS_TWO, 8'hFF, 1'b0);
        rdc(SOR_OFF_OPTIONS_TWO, 8'hDF);
        chk({2'h0, capture, opt_two}, 8'h3F);
        cmp_out_i        = 1'b0;
        timer1_ch0_pin_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk({2'h0, capture, opt_two}, 8'h1F);
        host.write_reg(SOR_OFF_OPTIONS_TWO, 8'h00, 1'b0);
        rdc(SOR_OFF_OPTIONS_TWO, 8'hC0);
        chk({2'h0, capture, opt_two}, 8'h20);
        host.write_reg(SOR_OFF_DEBUG_FORCE, 8'h00, 1'b1);
        watch(0, 4, 1'b0, 1'b0, 1'b0);
        host.write_reg(SOR_OFF_DEBUG_FORCE, 8'h01, 1'b1);
        watch(0, 3, 1'b1, 1'b0, 1'b0);
        // slow clock, shortest timeout: two ticks
        rst(8'h40, 8'h00);
        rdc(SOR_OFF_OPTIONS_ONE, 8'h40);
        watch(3, 12, 1'b1, 1'b0, 1'b1);
        // bus clock, longest timeout: 128 cycles
        rst(8'hC0, 8'h80);
        repeat (3)
        begin
            watch(3, 60, 1'b0, 1'b0, 1'b0);
            host.service();
        end
        watch(3, 110, 1'b0, 1'b0, 1'b0);
        watch(3, 30, 1'b1, 1'b0, 1'b0);
        rst(8'hC0, 8'h80);
        host.write_reg(SOR_OFF_RESET_STATUS, 8'h12, 1'b0);
        watch(3, 3, 1'b1, 1'b0, 1'b0);
        rst(8'hC0, 8'hC0);
        host.write_reg(SOR_OFF_RESET_STATUS, SOR_KEY_FIRST, 1'b0);
        watch(3, 3, 1'b1, 1'b0, 1'b0);
        rst(8'hC0, 8'hC0);
        watch(3, 100, 1'b0, 1'b0, 1'b0);
        host.service();
        watch(3, 60, 1'b0, 1'b0, 1'b0);
        rst(8'hC0, 8'h40);
        host.service();
        watch(3, 5, 1'b0, 1'b0, 1'b0);
        summarize();
    end
endmodule
